// file: hdl/bps_boot_select.v
// boot path selector top with memory sequencer and axi4-lite registers
`timescale 1ns/10ps
`include "bps_defines.vh"
module bps_boot_select #(
  parameter AW = 17,
  parameter CW = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // startup trigger
  input wire wake,
  // byte memory port (ram, flash window selected by mem_flash)
  output reg mem_req,
  output reg mem_we,
  output reg mem_flash,
  output reg [AW-1:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  // card module and button
  input wire card_module,
  input wire card_present,
  input wire card_format_ok,
  input wire card_boot_file,
  input wire [CW-1:0] card_id,
  input wire scan_button,
  // outcome
  output reg [2:0] boot_path,
  output reg [15:0] boot_entry,
  output reg power_fail,
  output reg boot_done,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ****************************************
  // state and registers
  // ****************************************
  localparam S_IDLE = 4'd0;
  localparam S_RD = 4'd1;
  localparam S_EVAL = 4'd2;
  localparam S_DECIDE = 4'd3;
  localparam S_COPY_RD = 4'd4;
  localparam S_COPY_WR = 4'd5;
  localparam S_MARK = 4'd6;
  localparam S_ID_WR = 4'd7;
  localparam S_DONE = 4'd8;
  reg [3:0] state;
  reg [2:0] step;
  reg [15:0] ram_sig;
  reg [15:0] flash_sig;
  reg [15:0] stored_id;
  reg [6:0] cond;
  reg [7:0] copy_byte;
  reg [AW-1:0] copy_addr;
  reg mark_idx;
  reg id_idx;
  reg [1:0] ctrl;
  reg [15:0] int_sig;
  reg start_req;
  reg quit_seen;
  wire ram_valid;
  wire ram_quit;
  wire flash_valid;
  wire int_valid;
  wire [2:0] dec_path;
  reg eval_load;
  reg cmp_load;
  localparam [15:0] SIG_VALID = `BPS_SIG_VALID;
  // ****************************************
  // comparators and decoder
  // ****************************************
  bps_sig_check #(.W(16)) u_ram_ok (
    .aclk(aclk), .aresetn(aresetn), .load(cmp_load),
    .value(ram_sig), .marker(`BPS_SIG_VALID), .match(ram_valid)
  );
  bps_sig_check #(.W(16)) u_ram_quit (
    .aclk(aclk), .aresetn(aresetn), .load(cmp_load),
    .value(ram_sig), .marker(`BPS_SIG_QUIT), .match(ram_quit)
  );
  bps_sig_check #(.W(16)) u_flash_ok (
    .aclk(aclk), .aresetn(aresetn), .load(cmp_load),
    .value(flash_sig), .marker(`BPS_SIG_VALID), .match(flash_valid)
  );
  bps_sig_check #(.W(16)) u_int_ok (
    .aclk(aclk), .aresetn(aresetn), .load(cmp_load),
    .value(int_sig), .marker(`BPS_SIG_VALID), .match(int_valid)
  );
  bps_path_decode u_dec (
    .aclk(aclk), .aresetn(aresetn), .load(eval_load),
    .cond(cond), .path(dec_path)
  );
  wire card_ok = card_module & card_present & card_format_ok &
    card_boot_file;
  // ****************************************
  // startup sequencer
  // ****************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= S_IDLE;
      step <= 3'd0;
      ram_sig <= 16'h0000;
      flash_sig <= 16'h0000;
      stored_id <= 16'h0000;
      cond <= 7'h00;
      copy_byte <= 8'h00;
      copy_addr <= {AW{1'b0}};
      mark_idx <= 1'b0;
      id_idx <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_flash <= 1'b0;
      mem_addr <= {AW{1'b0}};
      mem_wdata <= 8'h00;
      boot_path <= `BPS_P_NONE;
      boot_entry <= 16'h0000;
      power_fail <= 1'b0;
      boot_done <= 1'b0;
      eval_load <= 1'b0;
      cmp_load <= 1'b0;
      start_req <= 1'b1;
      quit_seen <= 1'b0;
    end
    else
    begin
      eval_load <= 1'b0;
      cmp_load <= 1'b0;
      if (wake)
        start_req <= 1'b1;
      case (state)
        S_IDLE:
        begin
          if (start_req || wake)
          begin
            start_req <= 1'b0;
            boot_done <= 1'b0;
            power_fail <= 1'b0;
            boot_entry <= 16'h0000;
            boot_path <= `BPS_P_NONE;
            step <= 3'd0;
            state <= S_RD;
          end
        end
        S_RD:
        begin
          // steps: ram sig hi/lo, flash sig hi/lo, stored id hi/lo
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_flash <= (step[2:1] == 2'd1);
            case (step[2:1])
              2'd0: mem_addr <= `BPS_RAM_SIG_ADDR + {16'h0000, step[0]};
              2'd1: mem_addr <= `BPS_FLASH_SIG_ADDR + {16'h0000, step[0]};
              default: mem_addr <= `BPS_CARD_ID_ADDR + {16'h0000, step[0]};
            endcase
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            case (step)
              3'd0: ram_sig[15:8] <= mem_rdata;
              3'd1: ram_sig[7:0] <= mem_rdata;
              3'd2: flash_sig[15:8] <= mem_rdata;
              3'd3: flash_sig[7:0] <= mem_rdata;
              3'd4: stored_id[15:8] <= mem_rdata;
              default: stored_id[7:0] <= mem_rdata;
            endcase
            if (step == 3'd5)
            begin
              cmp_load <= 1'b1;
              state <= S_EVAL;
            end
            else
              step <= step + 3'd1;
          end
        end
        S_EVAL:
        begin
          // comparators settle this cycle
          if (!cmp_load)
          begin
            cond[`BPS_C_QUIT] <= ram_quit;
            cond[`BPS_C_INTOK] <= int_valid & ~ram_quit;
            cond[`BPS_C_EXTOK] <= ram_valid;
            cond[`BPS_C_CARD] <= card_ok & ~ram_quit;
            cond[`BPS_C_FLASH] <= flash_valid & ~ram_quit;
            cond[`BPS_C_SCAN] <= scan_button & ~ram_quit;
            cond[`BPS_C_NEWID] <= card_present & ~ram_quit &
              (card_id != stored_id);
            quit_seen <= ram_quit;
            eval_load <= 1'b1;
            state <= S_DECIDE;
          end
        end
        S_DECIDE:
        begin
          if (!eval_load)
          begin
            boot_path <= dec_path;
            copy_addr <= {AW{1'b0}};
            step <= 3'd0;
            case (dec_path)
              `BPS_P_OS_PF:
              begin
                power_fail <= 1'b1;
                boot_entry <= `BPS_OS_ENTRY;
                state <= S_DONE;
              end
              `BPS_P_OS:
              begin
                boot_entry <= `BPS_OS_ENTRY;
                state <= S_DONE;
              end
              `BPS_P_FLASH:
                state <= S_COPY_RD;
              `BPS_P_CARD:
              begin
                id_idx <= 1'b0;
                state <= S_ID_WR;
              end
              default:
              begin
                boot_entry <= 16'h0000;
                state <= S_DONE;
              end
            endcase
          end
        end
        S_COPY_RD:
        begin
          // flash bank 0 image below the signature pair into ram bank 0
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_flash <= 1'b1;
            mem_addr <= copy_addr | `BPS_FLASH_IMG_BASE;
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            copy_byte <= mem_rdata;
            state <= S_COPY_WR;
          end
        end
        S_COPY_WR:
        begin
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_flash <= 1'b0;
            mem_addr <= copy_addr;
            mem_wdata <= copy_byte;
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            if (copy_addr == `BPS_RAM_SIG_ADDR - 17'h00001)
            begin
              mark_idx <= 1'b0;
              state <= S_MARK;
            end
            else
            begin
              copy_addr <= copy_addr + 17'h00001;
              state <= S_COPY_RD;
            end
          end
        end
        S_MARK:
        begin
          // valid marker after the copy
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_flash <= 1'b0;
            mem_addr <= `BPS_RAM_SIG_ADDR + {16'h0000, mark_idx};
            mem_wdata <= mark_idx ? SIG_VALID[7:0] :
              SIG_VALID[15:8];
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            if (mark_idx)
            begin
              boot_entry <= `BPS_OS_ENTRY;
              state <= S_DONE;
            end
            else
              mark_idx <= 1'b1;
          end
        end
        S_ID_WR:
        begin
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_flash <= 1'b0;
            mem_addr <= `BPS_CARD_ID_ADDR + {16'h0000, id_idx};
            mem_wdata <= id_idx ? card_id[7:0] : card_id[15:8];
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            stored_id <= card_id;
            if (id_idx)
              state <= S_DONE;
            else
              id_idx <= 1'b1;
          end
        end
        S_DONE:
        begin
          boot_done <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `BPS_CTRL_RESET;
      int_sig <= `BPS_INTSIG_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_full && w_full)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `BPS_REG_CTRL:
            if (w_strb[0])
              ctrl <= w_data[1:0];
          `BPS_REG_INTSIG:
          begin
            if (w_strb[0])
              int_sig[7:0] <= w_data[7:0];
            if (w_strb[1])
              int_sig[15:8] <= w_data[15:8];
          end
          `BPS_REG_STATUS, `BPS_REG_COND, `BPS_REG_CARDID: ;
          default:
            s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `BPS_REG_CTRL: s_axi_rdata <= {30'h0, ctrl};
        `BPS_REG_STATUS: s_axi_rdata <= {20'h0, card_boot_file,
          card_format_ok, card_present, card_module, 1'b0, boot_path,
          1'b0, power_fail, boot_done, (state != S_IDLE)};
        `BPS_REG_COND: s_axi_rdata <= {25'h0, cond};
        `BPS_REG_CARDID: s_axi_rdata <= {16'h0, stored_id};
        `BPS_REG_INTSIG: s_axi_rdata <= {16'h0, int_sig};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// file: common/bps_defines.vh
// shared constants of the boot path selector
`ifndef BPS_DEFINES_VH
`define BPS_DEFINES_VH
// memory locations
`define BPS_RAM_SIG_ADDR 17'h07FF9
`define BPS_FLASH_SIG_ADDR 17'h0FFF9
`define BPS_CARD_ID_ADDR 17'h07FD1
`define BPS_OS_ENTRY 16'h7FFB
`define BPS_FLASH_IMG_BASE 17'h08000
// signature markers
`define BPS_SIG_VALID 16'h5AA5
`define BPS_SIG_QUIT 16'h3CC3
// condition vector bit positions
`define BPS_C_QUIT 0
`define BPS_C_INTOK 1
`define BPS_C_EXTOK 2
`define BPS_C_CARD 3
`define BPS_C_FLASH 4
`define BPS_C_SCAN 5
`define BPS_C_NEWID 6
// boot paths
`define BPS_P_NONE 3'h0
`define BPS_P_MONITOR 3'h1
`define BPS_P_OS 3'h2
`define BPS_P_OS_PF 3'h3
`define BPS_P_CARD 3'h4
`define BPS_P_FLASH 3'h5
// register byte offsets
`define BPS_REG_CTRL 8'h00
`define BPS_REG_STATUS 8'h04
`define BPS_REG_COND 8'h08
`define BPS_REG_CARDID 8'h0C
`define BPS_REG_INTSIG 8'h10
// status field positions
`define BPS_ST_BUSY 0
`define BPS_ST_DONE 1
`define BPS_ST_PF 2
`define BPS_ST_PATH 4
`define BPS_ST_CMOD 8
`define BPS_ST_CPRES 9
`define BPS_ST_CFMT 10
`define BPS_ST_CFILE 11
// reset values
`define BPS_INTSIG_RESET 16'h5AA5
`define BPS_CTRL_RESET 2'h1
`endif

// file: hdl/bps_sig_check.v
// signature pair comparator with registered result
`timescale 1ns/10ps
module bps_sig_check #(
  parameter W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // compare
  input wire load,
  input wire [W-1:0] value,
  input wire [W-1:0] marker,
  // result
  output reg match
);
  always @(posedge aclk)
  begin
    if (!aresetn)
      match <= 1'b0;
    else if (load)
      match <= (value == marker);
  end
endmodule

// file: hdl/bps_path_decode.v
// condition vector to boot path decoder
`timescale 1ns/10ps
`include "bps_defines.vh"
module bps_path_decode (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // decode
  input wire load,
  input wire [6:0] cond,
  // result
  output reg [2:0] path
);
  reg [2:0] next_path;
  always @*
  begin
    next_path = `BPS_P_MONITOR;
    if (cond[`BPS_C_QUIT])
      next_path = `BPS_P_MONITOR;
    else if (cond[`BPS_C_NEWID] && cond[`BPS_C_CARD])
      next_path = `BPS_P_CARD;
    else if (cond[`BPS_C_EXTOK] && !cond[`BPS_C_INTOK])
      next_path = `BPS_P_OS_PF;
    else if (cond[`BPS_C_EXTOK])
      next_path = `BPS_P_OS;
    else if (cond[`BPS_C_CARD])
      next_path = `BPS_P_CARD;
    else if (cond[`BPS_C_FLASH] && !cond[`BPS_C_SCAN])
      next_path = `BPS_P_FLASH;
    else if (cond[`BPS_C_FLASH])
      next_path = `BPS_P_MONITOR;
    else
      next_path = `BPS_P_MONITOR;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
      path <= `BPS_P_NONE;
    else if (load)
      path <= next_path;
  end
endmodule

// file: bench/bps_boot_select_checker.sv
// port assertions for the boot path selector
`timescale 1ns/10ps
`include "bps_defines.vh"
module bps_boot_select_checker #(
  parameter AW = 17,
  parameter CW = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // startup and memory port
  input wire wake,
  input wire mem_req,
  input wire mem_we,
  input wire mem_flash,
  input wire [AW-1:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_ack,
  // outcome
  input wire [2:0] boot_path,
  input wire [15:0] boot_entry,
  input wire power_fail,
  input wire boot_done
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire os_like = boot_path == `BPS_P_OS || boot_path == `BPS_P_OS_PF
    || boot_path == `BPS_P_FLASH;
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_flash) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before its answer");
  property p_req_gap;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("memory request not released after answer");
  property p_entry;
    boot_done |-> boot_entry == (os_like ? `BPS_OS_ENTRY : 16'h0000);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry address does not fit the path");
  property p_pf;
    boot_done |-> power_fail == (boot_path == `BPS_P_OS_PF);
  endproperty
  a_pf: assert property (p_pf)
    else $error("power fail flag does not fit the path");
  property p_hold_done;
    boot_done && !wake |=> boot_done && $stable(boot_path)
      && $stable(power_fail);
  endproperty
  a_hold_done: assert property (p_hold_done)
    else $error("final path changed without a new start");
  property p_path_set;
    boot_done |-> boot_path != `BPS_P_NONE && boot_path <= `BPS_P_FLASH;
  endproperty
  a_path_set: assert property (p_path_set)
    else $error("finished without a legal path");
  property p_wake_clear;
    wake && boot_done |-> ##[1:4] !boot_done;
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake did not restart the evaluation");
  property p_wake_read;
    wake && boot_done |-> ##[1:8]
      (mem_req && !mem_flash && mem_addr == `BPS_RAM_SIG_ADDR);
  endproperty
  a_wake_read: assert property (p_wake_read)
    else $error("wake did not start with the ram signature read");
  c_card: cover property (boot_done && boot_path == `BPS_P_CARD);
  c_pf: cover property (boot_done && boot_path == `BPS_P_OS_PF);
  c_copy: cover property (mem_ack && mem_flash &&
    mem_addr == `BPS_FLASH_IMG_BASE);
endmodule

// file: bench/bps_mem.sv
// byte memory model standing in for ram and flash bank 0
`timescale 1ns/10ps
module bps_mem (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // byte memory port
  input wire mem_req,
  input wire mem_we,
  input wire mem_flash,
  input wire [16:0] mem_addr,
  input wire [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // answer delay in cycles
  input wire [1:0] lat
);
  logic [7:0] ram [int];
  logic [7:0] fls [int];
  logic [17:0] log [$];
  int wr_cnt;
  int cnt;
  // unwritten bytes read as an address pattern, never as a marker
  function automatic logic [7:0] rd_byte(input logic f, input int a);
    if (f)
      return fls.exists(a) ? fls[a] : a[7:0] ^ 8'hA5;
    return ram.exists(a) ? ram[a] : a[7:0] ^ 8'h5A;
  endfunction
  always @(posedge aclk)
  begin
    // data lines scramble outside the answer cycle
    mem_rdata <= ~mem_rdata;
    mem_ack <= 1'h0;
    if (!aresetn)
    begin
      mem_rdata <= 8'h00;
      cnt <= 0;
    end
    else if (mem_req && !mem_ack)
    begin
      if (cnt < lat)
        cnt <= cnt + 1;
      else
      begin
        cnt <= 0;
        mem_ack <= 1'h1;
        if (mem_we)
        begin
          ram[mem_addr] = mem_wdata;
          wr_cnt++;
        end
        else
        begin
          log.push_back({mem_flash, mem_addr});
          mem_rdata <= rd_byte(mem_flash, mem_addr);
        end
      end
    end
  end
endmodule

// file: bench/boot_path_selector_tb.sv
// self-checking bench for the boot path selector
`timescale 1ns/10ps
`include "bps_defines.vh"
module boot_path_selector_tb;
  typedef struct packed {
    logic [15:0] ram;
    logic [15:0] fls;
    logic iok;
    logic [3:0] crd;
    logic dif;
    logic scn;
    logic [6:0] cnd;
    logic [2:0] pth;
  } bps_row_t;
  bps_row_t rows [10];
  bps_row_t r;
  logic aclk, aresetn, wake, scan_button;
  logic [3:0] crd;
  logic [15:0] card_id;
  logic [1:0] lat, rd_resp, wr_resp;
  wire mem_req, mem_we, mem_flash, mem_ack, power_fail, boot_done;
  wire [16:0] mem_addr;
  wire [7:0] mem_wdata, mem_rdata;
  wire [2:0] boot_path;
  wire [15:0] boot_entry;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int bad_count, compares;

  bps_boot_select i_bps_boot_select (
    .aclk(aclk), .aresetn(aresetn), .wake(wake),
    .mem_req(mem_req), .mem_we(mem_we), .mem_flash(mem_flash),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .card_module(crd[0]), .card_present(crd[1]),
    .card_format_ok(crd[2]), .card_boot_file(crd[3]), .card_id(card_id),
    .scan_button(scan_button), .boot_path(boot_path),
    .boot_entry(boot_entry), .power_fail(power_fail),
    .boot_done(boot_done), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  bps_mem i_bps_mem (
    .aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_flash(mem_flash), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));

  always #2.5 aclk = ~aclk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 100);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    chk("bvalid", 1'h1, s_axi_bvalid);
  endtask

  task axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 100);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk("rvalid", 1'h1, s_axi_rvalid);
  endtask

  task wait_done(input logic v);
    int n;
    n = 0;
    while (boot_done !== v && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    chk("boot_done", v, boot_done);
  endtask

  // preset memory and card, then pulse wake
  task start(input bps_row_t s);
    @(posedge aclk);
    crd <= s.crd;
    scan_button <= s.scn;
    card_id <= s.dif ? 16'hBEEF : 16'h1234;
    i_bps_mem.ram[32'h7FF9] = s.ram[15:8];
    i_bps_mem.ram[32'h7FFA] = s.ram[7:0];
    i_bps_mem.fls[32'hFFF9] = s.fls[15:8];
    i_bps_mem.fls[32'hFFFA] = s.fls[7:0];
    i_bps_mem.ram[32'h7FD1] = 8'h12;
    i_bps_mem.ram[32'h7FD2] = 8'h34;
    i_bps_mem.log.delete();
    i_bps_mem.wr_cnt = 0;
    axi_wr(`BPS_REG_INTSIG, s.iok ? 32'h5AA5 : 32'h0);
    chk("bresp", 2'h0, wr_resp);
    @(posedge aclk);
    wake <= 1'h1;
    @(posedge aclk);
    wake <= 1'h0;
  endtask

  initial
  begin
    #400000;
    chk("watchdog", 1'h0, 1'h1);
    results;
  end

  initial
  begin
    aclk = 0; aresetn = 0; wake = 0; crd = 0; scan_button = 0; lat = 0;
    card_id = 16'h1234; s_axi_awaddr = 0; s_axi_araddr = 0;
    s_axi_wdata = 0; s_axi_wstrb = 4'hF; s_axi_awvalid = 0;
    s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0;
    s_axi_rready = 0; bad_count = 0; compares = 0;
    // ram, flash, int ok, card, new id, scan, cond, path
    rows[0] = {16'h3CC3, 16'h5AA5, 1'h1, 4'hF, 1'h1, 1'h1, 7'h01,
      3'h1};
    rows[1] = {16'h5AA5, 16'h0000, 1'h1, 4'h0, 1'h0, 1'h0, 7'h06,
      3'h2};
    rows[2] = {16'h5AA5, 16'h0000, 1'h0, 4'h0, 1'h0, 1'h0, 7'h04,
      3'h3};
    rows[3] = {16'h5AA5, 16'h5AA5, 1'h0, 4'hF, 1'h0, 1'h1, 7'h3C,
      3'h3};
    rows[4] = {16'h0000, 16'h5AA5, 1'h1, 4'hF, 1'h0, 1'h0, 7'h1A,
      3'h4};
    rows[5] = {16'h5AA5, 16'h0000, 1'h1, 4'hF, 1'h1, 1'h0, 7'h4E,
      3'h4};
    rows[6] = {16'h1234, 16'h5AA5, 1'h0, 4'h0, 1'h0, 1'h1, 7'h30,
      3'h1};
    rows[7] = {16'h1234, 16'h0000, 1'h1, 4'h0, 1'h0, 1'h1, 7'h22,
      3'h1};
    rows[8] = {16'h0000, 16'h0000, 1'h0, 4'h0, 1'h0, 1'h0, 7'h00,
      3'h1};
    rows[9] = {16'h1234, 16'h0000, 1'h0, 4'h3, 1'h1, 1'h0, 7'h40,
      3'h1};
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    wait_done(1'h1);
    chk("reset_path", `BPS_P_MONITOR, boot_path);
    axi_rd(`BPS_REG_CTRL);
    chk("ctrl_reset", 32'h1, rd_data);
    axi_rd(`BPS_REG_INTSIG);
    chk("intsig_reset", 32'h5AA5, rd_data);
    axi_rd(8'h40);
    chk("unmapped_resp", 2'h2, rd_resp);
    chk("unmapped_data", 32'h0, rd_data);
    axi_wr(8'h40, 32'h0);
    chk("unmapped_bresp", 2'h2, wr_resp);
    for (int i = 0; i < 10; i++)
    begin
      r = rows[i];
      lat <= 2'(i % 3);
      start(r);
      wait_done(1'h0);
      wait_done(1'h1);
      chk("path", r.pth, boot_path);
      chk("power_fail", r.pth == 3'h3, power_fail);
      chk("entry", r.pth[1] ? 16'h7FFB : 16'h0, boot_entry);
      chk("rd_ram", {1'h0, 17'h07FF9}, i_bps_mem.log[0]);
      if (r.ram != 16'h3CC3)
        chk("rd_flash", {1'h1, 17'h0FFF9}, i_bps_mem.log[2]);
      chk("writes", r.pth == 3'h4 ? 2 : 0, i_bps_mem.wr_cnt);
      chk("stored_id", r.pth == 3'h4 ? card_id : 16'h1234,
        {i_bps_mem.ram[32'h7FD1], i_bps_mem.ram[32'h7FD2]});
      axi_rd(`BPS_REG_CARDID);
      chk("cardid_reg", r.pth == 3'h4 ? card_id : 16'h1234,
        rd_data);
      axi_rd(`BPS_REG_COND);
      chk("cond", r.cnd, rd_data);
      axi_rd(`BPS_REG_STATUS);
      chk("status", {r.crd, r.pth, r.pth == 3'h3, 2'h2},
        {rd_data[11:8], rd_data[6:4], rd_data[2:0]});
    end
    // flash copy, cut short by a reset in mid-copy
    lat <= 2'h0;
    start({16'h0000, 16'h5AA5, 1'h0, 4'h0, 1'h0, 1'h0, 7'h10,
      3'h5});
    for (int n = 0; n < 300 && i_bps_mem.wr_cnt < 1; n++)
      @(posedge aclk);
    chk("copy_src", {1'h1, 17'h08000}, i_bps_mem.log[6]);
    chk("copy_byte", 8'hA5, i_bps_mem.ram[0]);
    chk("copy_busy", 1'h0, boot_done);
    i_bps_mem.ram[32'h7FF9] = 8'h5A;
    i_bps_mem.ram[32'h7FFA] = 8'hA5;
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    chk("reset_outputs", 32'h0,
      {boot_done, boot_path, power_fail, mem_req, boot_entry});
    i_bps_mem.wr_cnt = 0;
    aresetn <= 1'h1;
    wait_done(1'h1);
    chk("restart_path", `BPS_P_OS, boot_path);
    chk("restart_writes", 0, i_bps_mem.wr_cnt);
    results;
  end
endmodule

bind bps_boot_select bps_boot_select_checker #(.AW(AW), .CW(CW))
  i_bps_boot_select_checker (
  .aclk(aclk), .aresetn(aresetn), .wake(wake), .mem_req(mem_req),
  .mem_we(mem_we), .mem_flash(mem_flash), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .boot_path(boot_path),
  .boot_entry(boot_entry), .power_fail(power_fail),
  .boot_done(boot_done));
